// ---- sim/fspc_checker_assertions.sv ----
// port checks for the self-programming controller
`timescale 1ns/1ns
`default_nettype none
module fspc_checker #(
  parameter PROG_CYCLES = 20
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus read handshake
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  // core and flash side
  input wire logic load_strobe,
  input wire logic load_valid,
  input wire logic global_irq_en,
  input wire logic boot_size_hi,
  input wire logic boot_size_lo,
  input wire logic ready_irq,
  input wire logic core_halt,
  input wire logic section_busy,
  input wire logic [11:0] boot_start,
  input wire logic flash_erase,
  input wire logic [6:0] flash_page
);
  logic [15:0] halt_cnt_reg;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar_taken;
    arvalid && arready;
  endsequence
  sequence s_halt_run;
    core_halt [*8];
  endsequence
  // length of the current halt
  always @(posedge aclk) begin
    if (!aresetn || !core_halt) halt_cnt_reg <= 16'h0;
    else halt_cnt_reg <= halt_cnt_reg + 16'h1;
  end
  AST_BOOT_MAP: assert property (
    boot_start == (boot_size_hi ? (boot_size_lo ? 12'hF80 : 12'hF00)
    : (boot_size_lo ? 12'hE00 : 12'hC00)))
    else $error("boot start mismatch");
  AST_IRQ_GATE: assert property (!global_irq_en |-> !ready_irq)
    else $error("ready request without global enable");
  AST_IRQ_BUSY: assert property (flash_erase |-> !ready_irq)
    else $error("ready request during erase");
  AST_HALT_AREA: assert property (
    flash_erase |-> core_halt == (flash_page >= 7'h60))
    else $error("halt does not match erased page");
  AST_HALT_RUN: assert property ($rose(core_halt) |-> s_halt_run)
    else $error("halt dropped early");
  AST_HALT_BOUND: assert property (halt_cnt_reg <= PROG_CYCLES + 4)
    else $error("halt too long");
  AST_BUSY_SET: assert property (
    flash_erase && flash_page < 7'h60 |-> ##[0:1] section_busy)
    else $error("busy flag not set");
  AST_LOAD_CAUSE: assert property (load_valid |-> $past(load_strobe))
    else $error("load result without load");
  AST_READ_ANSWER: assert property (s_ar_taken |=> rvalid)
    else $error("read not answered");
endmodule // fspc_checker
`default_nettype wire

// ---- sim/fspc_core_model.sv ----
// core model issuing store and load instruction strobes
`timescale 1ns/1ns
`default_nettype none
module fspc_core_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // requests and lag in cycles
  input wire logic go_store,
  input wire logic go_load,
  input wire logic [2:0] lag,
  // instruction strobes
  output logic store_strobe,
  output logic load_strobe
);
  logic [2:0] cnt_reg;
  logic pend_reg;
  logic kind_reg;
  // one-cycle strobe, at once or after lag cycles
  always @(posedge aclk) begin
    store_strobe <= 1'h0;
    load_strobe <= 1'h0;
    if (!aresetn) begin
      pend_reg <= 1'h0;
    end else if (go_store || go_load) begin
      cnt_reg <= lag;
      kind_reg <= go_load;
      pend_reg <= lag != 3'h0;
      store_strobe <= go_store && lag == 3'h0;
      load_strobe <= go_load && lag == 3'h0;
    end else if (pend_reg) begin
      cnt_reg <= cnt_reg - 3'h1;
      pend_reg <= cnt_reg != 3'h1;
      store_strobe <= cnt_reg == 3'h1 && !kind_reg;
      load_strobe <= cnt_reg == 3'h1 && kind_reg;
    end
  end
endmodule // fspc_core_model
`default_nettype wire

// ---- sim/fspc_top_tb.sv ----
// self-checking bench for the self-programming controller
`timescale 1ns/1ns
`default_nettype none
module fspc_top_tb;
  localparam int PC = 30;
  logic aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, bready = '0;
  logic arvalid = '0, rready = '0, go_s = '0, go_l = '0, global_irq_en = '0;
  logic boot_size_hi = '0, boot_size_lo = '0, awready, wready, bvalid, arready, rvalid;
  logic store_strobe, load_strobe, load_valid, ready_irq, core_halt, section_busy;
  logic flash_erase, flash_write;
  logic ce = 1'h1;
  logic [2:0] lag = '0;
  logic [3:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic [7:0] load_data, ldg;
  logic [11:0] boot_start;
  logic [6:0] flash_page;
  logic [15:0] flash_word, w16;
  logic [4:0] flash_word_addr;
  logic [11:0] bt [4] = '{12'hC00, 12'hE00, 12'hF00, 12'hF80};
  logic [31:0] pt [3] = '{32'h82, 32'h87, 32'h9F};
  logic [31:0] lk [3] = '{32'h1, 32'h0, 32'h3};
  logic [7:0] lx [3] = '{8'hFF, 8'h5A, 8'hC3};
  int err_total = 0, checks = 0, cyc = 0;
  // device, fuse bytes fixed
  fspc_top #(.PROG_CYCLES(PC)) dut (
    .aclk, .aresetn, .ce, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
    .rdata, .rresp, .store_strobe, .load_strobe, .global_irq_en, .fuse_low_byte(8'h5A),
    .fuse_high_byte(8'hC3), .boot_size_hi, .boot_size_lo, .load_data, .load_valid,
    .ready_irq, .core_halt, .section_busy, .boot_start, .flash_erase, .flash_write,
    .flash_page, .flash_word, .flash_word_addr);
  // core issuing the strobes
  fspc_core_model core_m (.aclk, .aresetn, .go_store(go_s), .go_load(go_l), .lag,
    .store_strobe, .load_strobe);
  // clock
  initial forever #50 aclk = ~aclk;
  // load capture and cycle limit
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (load_valid) ldg <= load_data;
    if (cyc == 20000) begin
      err_total++;
      end_sim;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    rs = bresp;
    bready <= 1'h0;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rd = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask
  // one instruction from the core, then let it settle
  task automatic core(input logic ld, input logic [2:0] l);
    go_s <= !ld;
    go_l <= ld;
    lag <= l;
    @(posedge aclk);
    go_s <= 1'h0;
    go_l <= 1'h0;
    repeat (4) @(posedge aclk);
  endtask
  task automatic cmd(input logic [7:0] c);
    axi_wr(4'h0, {24'h0, c});
    core(1'h0, 3'h0);
  endtask
  task automatic fill(input logic [4:0] i, input logic [15:0] d);
    axi_wr(4'h4, {26'h0, i, 1'h0});
    axi_wr(4'h8, {16'h0, d});
    cmd(8'h01);
  endtask
  task automatic peek(input logic [4:0] i);
    do @(negedge aclk); while (flash_word_addr !== i);
    w16 = flash_word;
  endtask
  task automatic idle;
    do axi_rd(4'h0); while (rd[0] !== 1'h0);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // test sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    axi_rd(4'h0);
    chk(rd, 32'h0);
    axi_rd(4'hC);
    chk(rd, 32'hFF);
    axi_rd(4'h2);
    chk(rs, 32'h2);
    axi_wr(4'h1, 32'h0);
    chk(rs, 32'h2);
    for (int i = 0; i < 4; i++) begin
      boot_size_hi <= i[1];
      boot_size_lo <= i[0];
      @(negedge aclk);
      chk(boot_start, bt[i]);
      @(posedge aclk);
    end
    $display("registers and boot map done");
    for (int i = 0; i < 3; i++) begin
      axi_wr(4'h0, pt[i]);
      axi_rd(4'h0);
      chk(rd, 32'h80);
    end
    global_irq_en <= 1'h1;
    @(negedge aclk);
    chk(ready_irq, 32'h1);
    $display("commands done");
    fill(5'h3, 16'hA5C3);
    peek(5'h3);
    chk(w16, 32'hA5C3);
    axi_rd(4'h0);
    chk(rd, 32'h0);
    axi_wr(4'h4, 32'hC);
    axi_wr(4'h8, 32'h1111);
    core(1'h0, 3'h0);
    peek(5'h6);
    chk(w16, 32'hFFFF);
    axi_wr(4'h0, 32'h3);
    core(1'h0, 3'h6);
    repeat (4) @(posedge aclk);
    axi_rd(4'h0);
    chk(rd, 32'h0);
    axi_wr(4'h4, 32'hA);
    axi_wr(4'h8, 32'h1234);
    axi_wr(4'h0, 32'h1);
    ce <= 1'h0;
    repeat (8) @(posedge aclk);
    ce <= 1'h1;
    core(1'h0, 3'h0);
    peek(5'h5);
    chk(w16, 32'h1234);
    $display("fill and expiry done");
    axi_wr(4'h4, 32'h17C0);
    cmd(8'h03);
    chk(flash_page, 32'h5F);
    chk(section_busy, 32'h1);
    axi_rd(4'h0);
    chk(rd, 32'h43);
    cmd(8'h11);
    chk(section_busy, 32'h1);
    idle;
    chk(rd, 32'h40);
    cmd(8'h11);
    chk(section_busy, 32'h0);
    fill(5'h2, 16'hBEEF);
    axi_wr(4'h4, 32'h17C0);
    cmd(8'h03);
    idle;
    fill(5'h4, 16'h0001);
    chk(section_busy, 32'h0);
    cmd(8'h11);
    peek(5'h2);
    chk(w16, 32'hFFFF);
    $display("erase done");
    axi_wr(4'h4, 32'hF800);
    cmd(8'h05);
    chk(core_halt, 32'h1);
    chk(section_busy, 32'h0);
    do @(posedge aclk); while (flash_write !== 1'h1);
    chk(flash_page, 32'h60);
    idle;
    chk(rd, 32'h0);
    $display("page write done");
    for (int i = 0; i < 3; i++) begin
      axi_wr(4'h4, lk[i]);
      axi_wr(4'h0, 32'h9);
      core(1'h1, 3'h0);
      chk(ldg, lx[i]);
    end
    axi_wr(4'h8, 32'hFFF0);
    cmd(8'h09);
    idle;
    axi_rd(4'hC);
    chk(rd, 32'hF0);
    $display("lock done");
    end_sim;
  end
endmodule // fspc_top_tb
bind fspc_top fspc_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.aclk, .aresetn, .arvalid,
  .arready, .rvalid, .load_strobe, .load_valid, .global_irq_en, .boot_size_hi, .boot_size_lo,
  .ready_irq, .core_halt, .section_busy, .boot_start, .flash_erase, .flash_page);
`default_nettype wire

// ---- src/fspc_boot_map.v ----
// boot section start and address classification
`timescale 1ns/1ns
`default_nettype none
`include "fspc_regs.vh"
module fspc_boot_map (
  // fuse and address
  input wire boot_size_hi,
  input wire boot_size_lo,
  input wire [11:0] word_addr,
  // classification
  output reg [11:0] boot_start,
  output wire in_halting_section
);
  // boot start from two fuse bits
  always @* begin
    case ({boot_size_hi, boot_size_lo})
      2'b11: boot_start = `FSPC_BOOT_11;
      2'b10: boot_start = `FSPC_BOOT_10;
      2'b01: boot_start = `FSPC_BOOT_01;
      default: boot_start = `FSPC_BOOT_00;
    endcase
  end
  // halting section fixed regardless of boot size
  assign in_halting_section = (word_addr >= `FSPC_HALT_START);
endmodule // fspc_boot_map
`default_nettype wire

// ---- src/fspc_page_buffer.v ----
// temporary page buffer, one word per slot
`timescale 1ns/1ns
`default_nettype none
module fspc_page_buffer #(
  parameter WORDS = 32,
  parameter AW = 5
) (
  // clock, reset and enable
  input wire aclk,
  input wire aresetn,
  input wire ce,
  // fill and clear
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [15:0] wr_data,
  input wire clear,
  // read port
  input wire [AW-1:0] rd_addr,
  output reg [15:0] rd_data
);
  reg [15:0] mem [0:WORDS-1];
  genvar i;
  // each slot: clear to erased value, else take its own fill
  generate
    for (i = 0; i < WORDS; i = i + 1) begin : g_slot
      always @(posedge aclk) begin
        if (!aresetn) begin
          mem[i] <= 16'hFFFF;
        end else if (ce) begin
          if (clear) begin
            mem[i] <= 16'hFFFF;
          end else if (wr_en && wr_addr == i) begin
            mem[i] <= wr_data;
          end
        end
      end
    end
  endgenerate
  // registered read
  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_data <= 16'h0000;
    end else if (ce) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // fspc_page_buffer
`default_nettype wire

// ---- src/fspc_regs.vh ----
// constants for the flash self-programming controller
//Contract
//- boot fuse codes 11,10,01,00 give boot start 0xF80,0xF00,0xE00,0xC00
//- pages below 0xC00 are concurrent-read section, 0xC00-0xFFF halting section
//- twelve-bit word address, 32-word pages, pointer bits 12:6 pick the page
//- pointer bits 5:1 pick buffer word; keep zero for page write
//- pointer bits 15:13 ignored; bit 0 zero for stores, byte select for loads
//- ready interrupt requested while enable and global flag set and store enable clear
//- erase or write to concurrent-read section sets busy flag and blocks reads
//- busy flag clears on re-enable after completion or when a buffer fill starts
//- control bit 5 reads as zero
//- re-enable plus store enable, then a store within four cycles, re-enables section
//- re-enable refused while erase or write still runs
//- re-enable aborts buffer loading; buffer cleared on re-enable
//- lock-set with store in four cycles programs lock bits from low register
//- load within three cycles of lock-set arming returns lock or fuse byte
//- page-write armed store writes buffer to addressed page
//- page-erase armed store erases addressed page
//- write and erase bits clear on completion or four-cycle timeout
//- core halted for whole erase or write in the halting section
//- store enable alone: store puts register pair into addressed buffer word
//- store enable arms four cycles; clears after store or timeout, held during operation
//- other lower five bit patterns have no effect
//- pointer 0x0001 lock bits, 0x0000 fuse low, 0x0003 fuse high
//- programmed bits read zero, unprogrammed read one
//- erase, write and lock write take between 3.7 ms and 4.5 ms
`ifndef FSPC_REGS_VH
`define FSPC_REGS_VH
`define FSPC_ADDR_CTRL 4'h0
`define FSPC_ADDR_PTR 4'h4
`define FSPC_ADDR_DATA 4'h8
`define FSPC_ADDR_STAT 4'hC
`define FSPC_BIT_STORE_EN 0
`define FSPC_BIT_ERASE 1
`define FSPC_BIT_WRITE 2
`define FSPC_BIT_LOCK 3
`define FSPC_BIT_REEN 4
`define FSPC_BIT_BUSY 6
`define FSPC_BIT_IRQEN 7
`define FSPC_CTRL_RESET 8'h00
`define FSPC_CMD_FILL 5'h01
`define FSPC_CMD_ERASE 5'h03
`define FSPC_CMD_WRITE 5'h05
`define FSPC_CMD_LOCK 5'h09
`define FSPC_CMD_REEN 5'h11
`define FSPC_ARM_CYCLES 3'd4
`define FSPC_LOAD_CYCLES 3'd3
`define FSPC_PROG_US 4000
`define FSPC_CLK_MHZ 10
`define FSPC_PROG_CYCLES (`FSPC_PROG_US * `FSPC_CLK_MHZ)
`define FSPC_BOOT_11 12'hF80
`define FSPC_BOOT_10 12'hF00
`define FSPC_BOOT_01 12'hE00
`define FSPC_BOOT_00 12'hC00
`define FSPC_HALT_START 12'hC00
`define FSPC_LOCK_RESET 8'hFF
`endif

// ---- src/fspc_top.v ----
// flash self-programming controller with axi4-lite control
`timescale 1ns/1ns
`default_nettype none
`include "fspc_regs.vh"
module fspc_top #(
  parameter PROG_CYCLES = `FSPC_PROG_CYCLES
) (
  // clock, reset, enable
  input wire aclk,
  input wire aresetn,
  input wire ce,
  // axi4-lite write address
  input wire awvalid,
  output wire awready,
  input wire [3:0] awaddr,
  // axi4-lite write data
  input wire wvalid,
  output wire wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  // axi4-lite write response
  output reg bvalid,
  input wire bready,
  output reg [1:0] bresp,
  // axi4-lite read address
  input wire arvalid,
  output wire arready,
  input wire [3:0] araddr,
  // axi4-lite read data
  output reg rvalid,
  input wire rready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  // core side
  input wire store_strobe,
  input wire load_strobe,
  input wire global_irq_en,
  input wire [7:0] fuse_low_byte,
  input wire [7:0] fuse_high_byte,
  input wire boot_size_hi,
  input wire boot_size_lo,
  output reg [7:0] load_data,
  output reg load_valid,
  output wire ready_irq,
  output wire core_halt,
  output wire section_busy,
  output wire [11:0] boot_start,
  // flash array side
  output reg flash_erase,
  output reg flash_write,
  output reg [6:0] flash_page,
  output reg [15:0] flash_word,
  output reg [4:0] flash_word_addr
);
  // lock byte, command and arming window
  reg [7:0] lock_bits_reg;
  reg [4:0] cmd_reg;
  reg irq_en_reg;
  reg busy_flag_reg;
  reg [2:0] arm_cnt_reg;
  reg cmd_legal;
  // running erase, write or lock operation
  reg prog_run_reg;
  reg prog_halt_reg;
  reg prog_rww_reg;
  reg prog_write_reg;
  reg [31:0] prog_cnt_reg;
  // buffer scan, pointer and data word
  reg [4:0] wr_idx_reg;
  reg [15:0] ptr_reg;
  reg [15:0] data_reg;
  // axi write capture
  reg aw_got_reg;
  reg w_got_reg;
  reg [3:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  // pointer fields and buffer read
  wire [4:0] fill_idx;
  wire [6:0] page_sel;
  wire halting;
  wire [15:0] buf_rd;
  // decoded bus and store actions
  wire ctrl_wr;
  wire armed;
  wire do_fill;
  wire do_erase;
  wire do_write;
  wire do_lock;
  wire do_reen;
  wire [4:0] new_cmd;
  wire [7:0] ctrl_rd;
  wire do_wr;
  wire do_rd;
  // pointer fields: bits 15:13 unused, bit 0 only for loads
  assign page_sel = ptr_reg[12:6];
  assign fill_idx = ptr_reg[5:1];
  // classification of addressed page
  fspc_boot_map u_map (
    .boot_size_hi(boot_size_hi),
    .boot_size_lo(boot_size_lo),
    .word_addr({page_sel, 5'h00}),
    .boot_start(boot_start),
    .in_halting_section(halting)
  );
  // axi write channel capture
  assign awready = ce && !aw_got_reg && !bvalid; // no accept while frozen
  assign wready = ce && !w_got_reg && !bvalid;
  assign do_wr = aw_got_reg && w_got_reg && !bvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (do_wr) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (aw_addr_reg[1:0] == 2'b00) ? 2'b00 : 2'b10;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  // control register write decode
  assign ctrl_wr = do_wr && aw_addr_reg == `FSPC_ADDR_CTRL && w_strb_reg[0];
  assign new_cmd = w_data_reg[4:0];
  // only the five command patterns arm the window
  always @* begin
    case (new_cmd)
      `FSPC_CMD_FILL: cmd_legal = 1'b1;
      `FSPC_CMD_ERASE: cmd_legal = 1'b1;
      `FSPC_CMD_WRITE: cmd_legal = 1'b1;
      `FSPC_CMD_LOCK: cmd_legal = 1'b1;
      `FSPC_CMD_REEN: cmd_legal = 1'b1;
      default: cmd_legal = 1'b0;
    endcase
  end
  assign armed = cmd_reg[`FSPC_BIT_STORE_EN] && !prog_run_reg;
  // store actions, only while armed and within window
  assign do_fill = store_strobe && armed && cmd_reg == `FSPC_CMD_FILL;
  assign do_erase = store_strobe && armed && cmd_reg == `FSPC_CMD_ERASE;
  assign do_write = store_strobe && armed && cmd_reg == `FSPC_CMD_WRITE;
  assign do_lock = store_strobe && armed && cmd_reg == `FSPC_CMD_LOCK;
  assign do_reen = store_strobe && armed && cmd_reg == `FSPC_CMD_REEN;
  // command, window and operation timing
  always @(posedge aclk) begin
    if (!aresetn) begin
      cmd_reg <= 5'h00; // low five bits of the control reset value
      irq_en_reg <= 1'b0;
      busy_flag_reg <= 1'b0;
      arm_cnt_reg <= 3'd0;
      prog_run_reg <= 1'b0;
      prog_halt_reg <= 1'b0;
      prog_rww_reg <= 1'b0;
      prog_write_reg <= 1'b0;
      prog_cnt_reg <= 32'd0;
      lock_bits_reg <= `FSPC_LOCK_RESET;
      flash_erase <= 1'b0;
      flash_write <= 1'b0;
      flash_page <= 7'h00;
    end else if (ce) begin
      flash_erase <= 1'b0;
      flash_write <= 1'b0;
      if (ctrl_wr) begin
        irq_en_reg <= w_data_reg[`FSPC_BIT_IRQEN];
      end
      if (prog_run_reg) begin
        // store enable and command bit held for whole operation
        if (prog_cnt_reg == 32'd1) begin
          prog_run_reg <= 1'b0;
          prog_halt_reg <= 1'b0;
          cmd_reg <= 5'h00;
          if (prog_write_reg) begin
            flash_write <= 1'b1;
          end
        end
        prog_cnt_reg <= prog_cnt_reg - 32'd1;
      end else if (do_erase || do_write) begin
        prog_run_reg <= 1'b1;
        prog_cnt_reg <= PROG_CYCLES;
        prog_write_reg <= do_write;
        prog_halt_reg <= halting;
        prog_rww_reg <= !halting;
        flash_page <= page_sel;
        flash_erase <= do_erase;
        if (!halting) begin
          busy_flag_reg <= 1'b1;
        end
      end else if (do_lock) begin
        // lock write also takes a full programming time
        lock_bits_reg <= lock_bits_reg & data_reg[7:0];
        prog_run_reg <= 1'b1;
        prog_cnt_reg <= PROG_CYCLES;
        prog_write_reg <= 1'b0;
        prog_halt_reg <= 1'b0;
      end else if (do_fill) begin
        busy_flag_reg <= 1'b0;
        cmd_reg <= 5'h00;
      end else if (do_reen) begin
        busy_flag_reg <= 1'b0;
        cmd_reg <= 5'h00;
      end else if (ctrl_wr && !cmd_reg[`FSPC_BIT_STORE_EN] && cmd_legal) begin
        cmd_reg <= new_cmd;
        arm_cnt_reg <= `FSPC_ARM_CYCLES;
      end else if (cmd_reg[`FSPC_BIT_STORE_EN]) begin
        // window runs out without a store
        if (arm_cnt_reg == 3'd1) begin
          cmd_reg <= 5'h00;
        end
        arm_cnt_reg <= arm_cnt_reg - 3'd1;
      end
      if (!prog_run_reg && prog_rww_reg) begin
        prog_rww_reg <= 1'b0;
      end
    end
  end
  // buffer fill, and clear when section re-enabled
  fspc_page_buffer #(
    .WORDS(32),
    .AW(5)
  ) u_buf (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .wr_en(do_fill),
    .wr_addr(fill_idx),
    .wr_data(data_reg),
    .clear(do_reen),
    .rd_addr(wr_idx_reg),
    .rd_data(buf_rd)
  );
  // stream buffer to array continuously, one word per enabled cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      wr_idx_reg <= 5'h00;
      flash_word <= 16'h0000;
      flash_word_addr <= 5'h00;
    end else if (ce) begin
      wr_idx_reg <= wr_idx_reg + 5'h01;
      flash_word <= buf_rd;
      flash_word_addr <= wr_idx_reg - 5'h01;
    end
  end
  // readback of lock or fuse byte
  always @(posedge aclk) begin
    if (!aresetn) begin
      load_data <= 8'h00;
      load_valid <= 1'b0;
    end else if (ce) begin
      load_valid <= 1'b0;
      if (load_strobe && armed && cmd_reg == `FSPC_CMD_LOCK &&
          arm_cnt_reg > (`FSPC_ARM_CYCLES - `FSPC_LOAD_CYCLES)) begin
        load_valid <= 1'b1;
        case (ptr_reg[1:0])
          2'b01: load_data <= lock_bits_reg;
          2'b11: load_data <= fuse_high_byte;
          2'b00: load_data <= fuse_low_byte;
          default: load_data <= 8'hFF;
        endcase
      end
    end
  end
  // pointer and data registers, one byte lane per strobe
  always @(posedge aclk) begin
    if (!aresetn) begin
      ptr_reg <= 16'h0000;
      data_reg <= 16'h0000;
    end else if (ce && do_wr) begin
      if (aw_addr_reg == `FSPC_ADDR_PTR && w_strb_reg[0]) begin
        ptr_reg[7:0] <= w_data_reg[7:0];
      end
      if (aw_addr_reg == `FSPC_ADDR_PTR && w_strb_reg[1]) begin
        ptr_reg[15:8] <= w_data_reg[15:8];
      end
      if (aw_addr_reg == `FSPC_ADDR_DATA && w_strb_reg[0]) begin
        data_reg[7:0] <= w_data_reg[7:0];
      end
      if (aw_addr_reg == `FSPC_ADDR_DATA && w_strb_reg[1]) begin
        data_reg[15:8] <= w_data_reg[15:8];
      end
    end
  end
  // control readback with reserved bit zero
  assign ctrl_rd = {irq_en_reg, busy_flag_reg, 1'b0, cmd_reg};
  // axi read channel
  assign arready = ce && !rvalid; // no accept while frozen
  assign do_rd = arvalid && arready;
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= 2'b00;
    end else if (ce) begin
      if (do_rd) begin
        rvalid <= 1'b1;
        rresp <= 2'b00;
        case (araddr)
          `FSPC_ADDR_CTRL: rdata <= {24'h000000, ctrl_rd};
          `FSPC_ADDR_PTR: rdata <= {16'h0000, ptr_reg};
          `FSPC_ADDR_DATA: rdata <= {16'h0000, data_reg};
          `FSPC_ADDR_STAT: rdata <= {24'h000000, lock_bits_reg};
          default: begin
            rdata <= 32'h00000000;
            rresp <= 2'b10;
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
  // core-facing status
  assign ready_irq = irq_en_reg && global_irq_en && !cmd_reg[`FSPC_BIT_STORE_EN];
  assign core_halt = prog_run_reg && prog_halt_reg;
  assign section_busy = busy_flag_reg;
endmodule // fspc_top
`default_nettype wire
